// ### hdl/tec_pkg.sv
// Package: register map, field positions and carrier types
package tec_pkg;

  // Register offsets on the parallel port
  localparam logic [7:0] VIOLATION_COUNT_HIGH_ADDR = 8'h23;
  localparam logic [7:0] VIOLATION_COUNT_LOW_ADDR  = 8'h24;
  localparam logic [7:0] CRC_ERROR_COUNT_HIGH_ADDR = 8'h25;
  localparam logic [7:0] CRC_ERROR_COUNT_LOW_ADDR  = 8'h26;
  localparam logic [7:0] FRAME_ERROR_COUNT_ADDR    = 8'h27;
  localparam logic [7:0] LINK_RECEIVE_BYTE_ADDR    = 8'h28;
  localparam logic [7:0] LINK_MATCH_BYTE_A_ADDR    = 8'h29;
  localparam logic [7:0] LINK_MATCH_BYTE_B_ADDR    = 8'h2A;
  localparam logic [7:0] STATUS_REGISTER_TWO_ADDR  = 8'h21;
  localparam logic [7:0] LINK_TRANSMIT_BYTE_ADDR   = 8'h7E;
  localparam logic [7:0] INTERRUPT_MASK_TWO_ADDR   = 8'h7D;
  localparam logic [7:0] COMMON_CONTROL_TWO_ADDR   = 8'h1A;
  localparam logic [7:0] RECEIVE_CONTROL_TWO_ADDR  = 8'h1B;

  // common_control_two fields
  localparam int CC_DESTUFF_BIT = 0;
  localparam int CC_B8ZS_BIT    = 2;
  localparam int CC_ESF_BIT     = 3;
  localparam int CC_STUFF_BIT   = 4;

  // receive_control_two fields
  localparam int RC_ESF_EVENT_BIT = 0;
  localparam int RC_FS_COUNT_BIT  = 1;

  // status_register_two / interrupt_mask_two fields
  localparam int ST_RX_FULL_BIT  = 4;
  localparam int ST_TX_EMPTY_BIT = 3;
  localparam int ST_MATCH_BIT    = 2;

  // Reset values and counter limits
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] WIDE_COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] FRAME_COUNT_MAX  = 16'h00FF;

  // Link bit stuffing figures
  localparam logic [2:0] STUFF_RUN_LEN = 3'd5;
  localparam logic [2:0] LAST_BIT_IDX  = 3'd7;

  // Per-cycle events from the receive framer, same-clock pulses except the lossOfSync level
  typedef struct packed {
    logic lossOfSync;       // level: receiver not synchronized
    logic bpvEvent;         // bipolar violation seen
    logic b8zsCodeEvent;    // violation belongs to a valid B8ZS word
    logic multiframeEnd;    // receive multiframe boundary
    logic crcErrorEvent;    // CRC6 word error at multiframe end
    logic esfFramingError;  // ESF framing pattern bit error
    logic ftError;          // D4 terminal framing bit error
    logic fsError;          // D4 signaling framing bit error
    logic oneSecondTick;    // one-second timer boundary
  } tec_line_evt_s;

  typedef struct packed {
    logic [15:0] violations;
    logic [15:0] crcErrors;
    logic [7:0]  frameErrors;
  } tec_counts_s;

endpackage : tec_pkg

// ### hdl/tec_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             inValid,   // write request
  output logic                  inReady,   // room available
  input  wire logic [WIDTH-1:0] inData,    // write data
  output logic                  outValid,  // data available
  input  wire logic             outReady,  // reader takes word
  output logic      [WIDTH-1:0] outData    // head word
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
    $error("tec_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : gBadWidth
    $error("tec_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr != rdPtr;
  assign outData  = mem[rdPtr[AW-1:0]];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
    end else if (doWrite) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdPtr <= '0;
    end else if (doRead) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : tec_fifo
`default_nettype wire

// ### hdl/tec_error_link.sv
// Error counters and facility data link engine for a T1 framer
//
// What this block does
// - Keep 16-bit violation count, high byte then low byte registers.
// - In B8ZS mode, skip violations belonging to valid substitution words.
// - Violation counter keeps counting even during loss of sync.
// - Violation counter saturates at 65535, never wraps.
// - ESF event option: count multiframes with CRC error or sync loss.
// - In ESF, count CRC6 word errors in saturating 16-bit counter.
// - CRC and frame error counters pause while out of sync.
// - In ESF, count each ESF framing pattern bit error.
// - In D4, count Ft errors, plus Fs errors when enabled.
// - Frame error counter saturates at 255.
// - Shift received link bits LSB first into 8-bit byte register.
// - Full byte sets receive-full flag; unmasked drives interrupt low.
// - Byte matching either match register sets match flag, interrupt.
// - Destuffer drops a 0 after exactly five consecutive 1s.
// - A 0 after six or more 1s is kept.
// - Transmit host byte LSB first into link bit positions.
// - After 8 bits sent, set transmit-empty flag and interrupt.
// - Without a new host byte, resend the previous byte.
// - Stuffer inserts a 0 after every five consecutive 1s.
// - Counters shown are latched each second, then restarted.
// - Gating loss of sync means receiver unsynchronized to stream.
`timescale 1ns/1ps
`default_nettype none
module tec_error_link
  import tec_pkg::*;
#(
  parameter int TX_FIFO_DEPTH = 8
) (
  input  wire logic          sys_clk,        // 200 MHz system clock
  input  wire logic          rst,            // async reset, high
  input  wire logic [7:0]    regAddr,        // register address
  input  wire logic [7:0]    regWrData,      // register write data
  input  wire logic          regWr,          // write strobe, one cycle
  input  wire logic          regRd,          // read strobe, one cycle
  output logic      [7:0]    regRdData,      // read data, next cycle
  input  wire tec_line_evt_s lineEvt,        // framer events
  input  wire logic          linkRxValid,    // received link bit strobe
  input  wire logic          linkRxBit,      // received link bit
  input  wire logic          linkTxSlot,     // outgoing link bit slot
  output logic               linkTxBit,      // outgoing link bit
  output logic               txByteReady,    // transmit byte room
  output logic               secondaryIntN   // interrupt, active low
);

  if (TX_FIFO_DEPTH < 2) begin : gBadDepth
    $error("tec_error_link: TX_FIFO_DEPTH must be at least 2");
  end

  function automatic logic [15:0] satInc(input logic [15:0] v,
                                         input logic        inc,
                                         input logic [15:0] maxVal);
    satInc = (inc && v != maxVal) ? v + 16'h0001 : v;
  endfunction : satInc

  function automatic logic isWrite(input logic [7:0] addr,
                                   input logic [7:0] target,
                                   input logic       wr);
    isWrite = wr && (addr == target);
  endfunction : isWrite

  // Control and mask registers
  logic [7:0]  commonControlTwo;
  logic [7:0]  receiveControlTwo;
  logic [7:0]  interruptMaskTwo;
  logic [7:0]  linkMatchByteA;
  logic [7:0]  linkMatchByteB;
  logic [7:0]  statusRegisterTwo;

  logic esfMode;
  logic b8zsMode;
  logic destuffEn;
  logic stuffEn;
  logic esfEventMode;
  logic fsCountEn;

  assign esfMode      = commonControlTwo[CC_ESF_BIT];
  assign b8zsMode     = commonControlTwo[CC_B8ZS_BIT];
  assign destuffEn    = commonControlTwo[CC_DESTUFF_BIT];
  assign stuffEn      = commonControlTwo[CC_STUFF_BIT];
  assign esfEventMode = receiveControlTwo[RC_ESF_EVENT_BIT];
  assign fsCountEn    = receiveControlTwo[RC_FS_COUNT_BIT];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      commonControlTwo  <= CONTROL_RESET;
      receiveControlTwo <= CONTROL_RESET;
      interruptMaskTwo  <= MASK_RESET;
      linkMatchByteA    <= BYTE_RESET;
      linkMatchByteB    <= BYTE_RESET;
    end else begin
      if (isWrite(regAddr, COMMON_CONTROL_TWO_ADDR, regWr)) begin
        commonControlTwo <= regWrData;
      end
      if (isWrite(regAddr, RECEIVE_CONTROL_TWO_ADDR, regWr)) begin
        receiveControlTwo <= regWrData;
      end
      if (isWrite(regAddr, INTERRUPT_MASK_TWO_ADDR, regWr)) begin
        interruptMaskTwo <= regWrData;
      end
      if (isWrite(regAddr, LINK_MATCH_BYTE_A_ADDR, regWr)) begin
        linkMatchByteA <= regWrData;
      end
      if (isWrite(regAddr, LINK_MATCH_BYTE_B_ADDR, regWr)) begin
        linkMatchByteB <= regWrData;
      end
    end
  end

  // Error counters: live accumulation, shown copy per second
  tec_counts_s live;
  tec_counts_s shown;
  logic        mfHadSyncLoss;
  logic        violationInc;
  logic        crcInc;
  logic        frameInc;
  logic [15:0] nextViolations;
  logic [15:0] nextCrcErrors;
  logic [15:0] nextFrameErrors;

  // Remembers any sync loss inside the current multiframe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mfHadSyncLoss <= 1'b0;
    end else if (lineEvt.multiframeEnd) begin
      mfHadSyncLoss <= 1'b0;
    end else if (lineEvt.lossOfSync) begin
      mfHadSyncLoss <= 1'b1;
    end
  end

  always_comb begin
    if (esfEventMode) begin
      violationInc = lineEvt.multiframeEnd && (lineEvt.crcErrorEvent
                     || mfHadSyncLoss || lineEvt.lossOfSync);
    end else begin
      violationInc = lineEvt.bpvEvent
                     && !(b8zsMode && lineEvt.b8zsCodeEvent);
    end
    crcInc = esfMode && lineEvt.crcErrorEvent && !lineEvt.lossOfSync;
    if (esfMode) begin
      frameInc = lineEvt.esfFramingError && !lineEvt.lossOfSync;
    end else begin
      frameInc = (lineEvt.ftError || (fsCountEn && lineEvt.fsError))
                 && !lineEvt.lossOfSync;
    end
  end

  assign nextViolations  = satInc(live.violations, violationInc,
                                  WIDE_COUNT_MAX);
  assign nextCrcErrors   = satInc(live.crcErrors, crcInc, WIDE_COUNT_MAX);
  assign nextFrameErrors = satInc({8'h00, live.frameErrors}, frameInc,
                                  FRAME_COUNT_MAX);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      live  <= '0;
      shown <= '0;
    end else if (lineEvt.oneSecondTick) begin
      // Event in the tick cycle lands in the closing second
      shown.violations  <= nextViolations;
      shown.crcErrors   <= nextCrcErrors;
      shown.frameErrors <= nextFrameErrors[7:0];
      live              <= '0;
    end else begin
      live.violations  <= nextViolations;
      live.crcErrors   <= nextCrcErrors;
      live.frameErrors <= nextFrameErrors[7:0];
    end
  end

  // Receive path: destuffer, shifter and match
  logic [2:0] rxOnesRun;
  logic [7:0] rxShift;
  logic [2:0] rxBitIdx;
  logic [7:0] linkReceiveByte;
  logic       rxKeep;
  logic [7:0] rxAssembled;
  logic       rxByteDone;
  logic       rxMatch;
  logic       sixOrMoreOnes;

  // Run of ones stops counting at six; six means six or more
  assign sixOrMoreOnes = rxOnesRun > STUFF_RUN_LEN;
  assign rxKeep = linkRxValid && !(destuffEn && !linkRxBit
                  && rxOnesRun == STUFF_RUN_LEN && !sixOrMoreOnes);
  assign rxAssembled = {linkRxBit, rxShift[7:1]};
  assign rxByteDone  = rxKeep && rxBitIdx == LAST_BIT_IDX;
  assign rxMatch     = rxByteDone && (rxAssembled == linkMatchByteA
                       || rxAssembled == linkMatchByteB);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxOnesRun <= 3'd0;
    end else if (linkRxValid) begin
      if (!linkRxBit) begin
        rxOnesRun <= 3'd0;
      end else if (!sixOrMoreOnes) begin
        rxOnesRun <= rxOnesRun + 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxShift         <= BYTE_RESET;
      rxBitIdx        <= 3'd0;
      linkReceiveByte <= BYTE_RESET;
    end else if (rxKeep) begin
      rxShift  <= rxAssembled;
      rxBitIdx <= rxBitIdx + 3'd1;
      // Unread byte is simply overwritten by the next one
      if (rxByteDone) begin
        linkReceiveByte <= rxAssembled;
      end
    end
  end

  // Transmit path: host bytes through FIFO, serializer, stuffer
  logic [7:0] fifoHead;
  logic       fifoValid;
  logic       fifoPop;
  logic       txWriteReq;
  logic [7:0] linkTransmitByte;
  logic [7:0] txShift;
  logic [2:0] txBitIdx;
  logic [2:0] txOnesRun;
  logic       txStuffNow;
  logic [7:0] txByteSrc;
  logic       txDataBit;
  logic       txByteDone;

  assign txWriteReq = isWrite(regAddr, LINK_TRANSMIT_BYTE_ADDR, regWr);

  // Writes are dropped while txByteReady is low
  tec_fifo #(
    .WIDTH (8),
    .DEPTH (TX_FIFO_DEPTH)
  ) txFifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (txWriteReq),
    .inReady  (txByteReady),
    .inData   (regWrData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoHead)
  );

  assign txStuffNow = stuffEn && txOnesRun == STUFF_RUN_LEN;
  assign txByteSrc  = fifoValid ? fifoHead : linkTransmitByte;
  assign fifoPop    = linkTxSlot && !txStuffNow && txBitIdx == 3'd0;
  assign txDataBit  = (txBitIdx == 3'd0) ? txByteSrc[0] : txShift[0];
  assign txByteDone = linkTxSlot && !txStuffNow
                      && txBitIdx == LAST_BIT_IDX;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkTransmitByte <= BYTE_RESET;
      txShift          <= BYTE_RESET;
      txBitIdx         <= 3'd0;
    end else if (linkTxSlot && !txStuffNow) begin
      txBitIdx <= txBitIdx + 3'd1;
      if (txBitIdx == 3'd0) begin
        linkTransmitByte <= txByteSrc;
        txShift          <= {1'b0, txByteSrc[7:1]};
      end else begin
        txShift <= {1'b0, txShift[7:1]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkTxBit <= 1'b1;
      txOnesRun <= 3'd0;
    end else if (linkTxSlot) begin
      if (txStuffNow || !txDataBit) begin
        linkTxBit <= 1'b0;
        txOnesRun <= 3'd0;
      end else begin
        linkTxBit <= 1'b1;
        txOnesRun <= txOnesRun + 3'd1;
      end
    end
  end

  // Status flags: cleared by reading them, a new event wins
  logic [7:0] statusSet;
  logic [7:0] statusClear;

  always_comb begin
    statusSet                  = 8'h00;
    statusSet[ST_RX_FULL_BIT]  = rxByteDone;
    statusSet[ST_TX_EMPTY_BIT] = txByteDone;
    statusSet[ST_MATCH_BIT]    = rxMatch;
    statusClear = (regRd && regAddr == STATUS_REGISTER_TWO_ADDR)
                  ? statusRegisterTwo : 8'h00;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      statusRegisterTwo <= STATUS_RESET;
    end else begin
      statusRegisterTwo <= (statusRegisterTwo & ~statusClear) | statusSet;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      secondaryIntN <= 1'b1;
    end else begin
      secondaryIntN <= ~|(statusRegisterTwo & interruptMaskTwo);
    end
  end

  // Register read port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        VIOLATION_COUNT_HIGH_ADDR: regRdData <= shown.violations[15:8];
        VIOLATION_COUNT_LOW_ADDR:  regRdData <= shown.violations[7:0];
        CRC_ERROR_COUNT_HIGH_ADDR: regRdData <= shown.crcErrors[15:8];
        CRC_ERROR_COUNT_LOW_ADDR:  regRdData <= shown.crcErrors[7:0];
        FRAME_ERROR_COUNT_ADDR:    regRdData <= shown.frameErrors;
        LINK_RECEIVE_BYTE_ADDR:    regRdData <= linkReceiveByte;
        LINK_MATCH_BYTE_A_ADDR:    regRdData <= linkMatchByteA;
        LINK_MATCH_BYTE_B_ADDR:    regRdData <= linkMatchByteB;
        STATUS_REGISTER_TWO_ADDR:  regRdData <= statusRegisterTwo;
        LINK_TRANSMIT_BYTE_ADDR:   regRdData <= linkTransmitByte;
        INTERRUPT_MASK_TWO_ADDR:   regRdData <= interruptMaskTwo;
        COMMON_CONTROL_TWO_ADDR:   regRdData <= commonControlTwo;
        RECEIVE_CONTROL_TWO_ADDR:  regRdData <= receiveControlTwo;
        default:                   regRdData <= 8'h00;
      endcase
    end
  end

endmodule : tec_error_link
`default_nettype wire

// ### tb/tec_error_link_sva.sv
// Port-level checker for the error counter and link block
`timescale 1ns/1ps
`default_nettype none
module tec_error_link_chk
  import tec_pkg::*;
(
  input wire logic          sys_clk,      // clock
  input wire logic          rst,          // reset
  input wire logic [7:0]    regAddr,      // address
  input wire logic [7:0]    regWrData,    // write data
  input wire logic          regWr,        // write strobe
  input wire logic          regRd,        // read strobe
  input wire logic [7:0]    regRdData,    // read data
  input wire tec_line_evt_s lineEvt,      // framer events
  input wire logic          linkRxValid,  // rx strobe
  input wire logic          linkRxBit,    // rx bit
  input wire logic          linkTxSlot,   // tx slot
  input wire logic          linkTxBit,    // tx bit
  input wire logic          txByteReady,  // fifo room
  input wire logic          secondaryIntN // interrupt, low
);
  logic [3:0] accHist;
  logic [3:0] lnkHist;

  // Recent host or link activity, the only causes of interrupt moves
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      accHist <= '0;
      lnkHist <= '0;
    end else begin
      accHist <= {accHist[2:0], regRd | regWr};
      lnkHist <= {lnkHist[2:0], linkRxValid | linkTxSlot};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr_a;
    regWr && regAddr == LINK_MATCH_BYTE_A_ADDR;
  endsequence
  sequence s_rd_a;
    regRd && regAddr == LINK_MATCH_BYTE_A_ADDR;
  endsequence

  property p_rst_out;
    $fell(rst) |-> regRdData == 8'h00 && linkTxBit && secondaryIntN
      && txByteReady;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not at reset levels");
  property p_rd_unmapped;
    regRd && regAddr == 8'h00 |=> regRdData == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_rd_hold;
    !regRd |=> $stable(regRdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_tx_hold;
    !linkTxSlot |=> $stable(linkTxBit);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("link bit moved outside a slot");
  property p_room_cause;
    $rose(txByteReady) |-> $past(linkTxSlot) || $past(linkTxSlot, 2);
  endproperty
  a_room_cause: assert property (p_room_cause)
    else $error("fifo room without a slot");
  property p_full_cause;
    $fell(txByteReady) |-> $past(regWr && regAddr == LINK_TRANSMIT_BYTE_ADDR);
  endproperty
  a_full_cause: assert property (p_full_cause)
    else $error("fifo full without a write");
  property p_int_rise;
    $rose(secondaryIntN) |-> accHist != 4'h0;
  endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("interrupt released without host access");
  property p_int_fall;
    $fell(secondaryIntN) |-> (lnkHist | accHist) != 4'h0;
  endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("interrupt raised without a cause");
  property p_match_rw;
    s_wr_a ##2 s_rd_a |=> regRdData == $past(regWrData, 3);
  endproperty
  a_match_rw: assert property (p_match_rw)
    else $error("match byte readback wrong");
endmodule : tec_error_link_chk

bind tec_error_link tec_error_link_chk u_chk (.sys_clk, .rst, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .lineEvt, .linkRxValid,
  .linkRxBit, .linkTxSlot, .linkTxBit, .txByteReady, .secondaryIntN);
`default_nettype wire

// ### tb/tec_link_partner.sv
// Line-side model: feeds received link bits, opens transmit slots
`timescale 1ns/1ps
`default_nettype none
module tec_link_partner (
  input  wire logic sys_clk,     // clock
  output logic      linkRxValid, // rx strobe
  output logic      linkRxBit,   // rx bit
  output logic      linkTxSlot,  // tx slot
  input  wire logic linkTxBit    // tx bit
);
  initial begin
    linkRxValid = 1'b0;
    linkRxBit   = 1'b1;
    linkTxSlot  = 1'b0;
  end

  task automatic send_bit(input logic b);
    repeat (1 + $urandom % 3) @(posedge sys_clk);
    linkRxValid <= 1'b1;
    linkRxBit   <= b;
    @(posedge sys_clk);
    linkRxValid <= 1'b0;
    // Idle line inverted so a stale bit cannot pass
    linkRxBit   <= ~b;
  endtask : send_bit

  task automatic tx_slot(output logic b);
    repeat (1 + $urandom % 3) @(posedge sys_clk);
    linkTxSlot <= 1'b1;
    @(posedge sys_clk);
    linkTxSlot <= 1'b0;
    #1 b = linkTxBit;
  endtask : tx_slot
endmodule : tec_link_partner
`default_nettype wire

// ### tb/tec_error_link_test.sv
// Self-checking bench: counters, receive and transmit link paths
`timescale 1ns/1ps
`default_nettype none
module tec_error_link_test
  import tec_pkg::*;
;
  logic          sys_clk, rst, regWr, regRd, linkTxSlot;
  logic          linkRxValid, linkRxBit, linkTxBit, txByteReady;
  logic          secondaryIntN;
  logic [7:0]    regAddr, regWrData, regRdData;
  tec_line_evt_s lineEvt;
  int            num_errors, n_compared, losSeen;
  int            cycles = 0;

  tec_error_link #(.TX_FIFO_DEPTH(8)) u_dut (.sys_clk, .rst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .lineEvt, .linkRxValid,
    .linkRxBit, .linkTxSlot, .linkTxBit, .txByteReady, .secondaryIntN);
  tec_link_partner u_far (.sys_clk, .linkRxValid, .linkRxBit, .linkTxSlot,
    .linkTxBit);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr     <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  task automatic drv(input tec_line_evt_s e);
    @(posedge sys_clk);
    lineEvt <= e;
  endtask : drv

  // One counting second in a mode; sat floods every counted error
  task automatic phase(input logic [7:0] cc, rc, input int n, input bit sat);
    tec_line_evt_s e;
    int v = 0, c = 0, f = 0;
    wr(COMMON_CONTROL_TWO_ADDR, cc);
    wr(RECEIVE_CONTROL_TWO_ADDR, rc);
    e = '0;
    e.oneSecondTick = 1'b1;
    drv(e);
    repeat (n) begin
      e = sat ? tec_line_evt_s'(9'h0BC) : tec_line_evt_s'(9'($urandom));
      e.oneSecondTick = 1'b0;
      e.multiframeEnd |= e.crcErrorEvent;
      losSeen |= int'(e.lossOfSync);
      if (rc[RC_ESF_EVENT_BIT])
        v += int'(e.multiframeEnd && (e.crcErrorEvent || losSeen != 0));
      else
        v += int'(e.bpvEvent && !(cc[CC_B8ZS_BIT] && e.b8zsCodeEvent));
      if (e.multiframeEnd)
        losSeen = 0;
      c += int'(!e.lossOfSync && cc[CC_ESF_BIT] && e.crcErrorEvent);
      f += int'(!e.lossOfSync && (cc[CC_ESF_BIT] ? e.esfFramingError
           : e.ftError || rc[RC_FS_COUNT_BIT] && e.fsError));
      drv(e);
    end
    e = '0;
    e.oneSecondTick = 1'b1;
    drv(e);
    e.oneSecondTick = 1'b0;
    e.bpvEvent = 1'b1;
    drv(e);
    drv('0);
    if (f > 255)
      f = 255;
    if (v > 65535)
      v = 65535;
    if (c > 65535)
      c = 65535;
    rdchk(VIOLATION_COUNT_HIGH_ADDR, 8'(v >> 8));
    rdchk(VIOLATION_COUNT_LOW_ADDR, 8'(v));
    rdchk(CRC_ERROR_COUNT_HIGH_ADDR, 8'(c >> 8));
    rdchk(CRC_ERROR_COUNT_LOW_ADDR, 8'(c));
    rdchk(FRAME_ERROR_COUNT_ADDR, 8'(f));
    rdchk(VIOLATION_COUNT_LOW_ADDR, 8'(v));
  endtask : phase

  initial begin
    logic [7:0] d, ma, mb, sh;
    logic       b;
    int         run, k, ones;
    logic [7:0] txq[$];
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    lineEvt = '0;
    losSeen = 0;
    void'($urandom(32'h0BAC));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(8'h00, 8'h00);
    for (int a = 8'h21; a <= 8'h2A; a++)
      rdchk(8'(a), 8'h00);
    // Fill the fifo past its depth, ninth byte refused
    wr(COMMON_CONTROL_TWO_ADDR, 8'h10);
    wr(INTERRUPT_MASK_TWO_ADDR, 8'h08);
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom) | 8'h1F;
      if (i < 8)
        txq.push_back(d);
      wr(LINK_TRANSMIT_BYTE_ADDR, d);
    end
    #1 chk(8'(txByteReady), 8'h00);
    txq.push_back(txq[7]);
    ones = 0;
    foreach (txq[j])
      for (int n = 0; n < 8; n++) begin
        if (ones == 5) begin
          u_far.tx_slot(b);
          chk(8'(b), 8'h00);
          ones = 0;
        end
        u_far.tx_slot(b);
        chk(8'(b), 8'(txq[j][n]));
        ones = txq[j][n] ? ones + 1 : 0;
      end
    repeat (3) @(posedge sys_clk);
    #1 chk(8'(txByteReady), 8'h01);
    chk(8'(secondaryIntN), 8'h00);
    rd(STATUS_REGISTER_TWO_ADDR, d);
    chk(8'(d[ST_TX_EMPTY_BIT]), 8'h01);
    phase(8'h0C, 8'h00, 60, 1'b0);
    phase(8'h00, 8'h02, 60, 1'b0);
    phase(8'h08, 8'h01, 60, 1'b0);
    phase(8'h08, 8'h00, 65540, 1'b1);
    ma = 8'hA5;
    mb = 8'($urandom);
    wr(LINK_MATCH_BYTE_A_ADDR, ma);
    rdchk(LINK_MATCH_BYTE_A_ADDR, ma);
    wr(LINK_MATCH_BYTE_B_ADDR, mb);
    rdchk(LINK_MATCH_BYTE_B_ADDR, mb);
    wr(COMMON_CONTROL_TWO_ADDR, 8'h01);
    wr(INTERRUPT_MASK_TWO_ADDR, 8'h10);
    run = 0;
    k = 0;
    for (int i = 0; i < 72; i++) begin
      b = (i < 8) ? ma[i] : ($urandom % 4 != 0);
      u_far.send_bit(b);
      if (!(b == 1'b0 && run == 5)) begin
        sh = {b, sh[7:1]};
        k++;
      end
      run = b ? run + 1 : 0;
      if (k == 8) begin
        k = 0;
        repeat (3) @(posedge sys_clk);
        #1 chk(8'(secondaryIntN), 8'h00);
        rdchk(LINK_RECEIVE_BYTE_ADDR, sh);
        rd(STATUS_REGISTER_TWO_ADDR, d);
        chk(8'(d[ST_RX_FULL_BIT]), 8'h01);
        chk(8'(d[ST_MATCH_BIT]), 8'(sh == ma || sh == mb));
        @(posedge sys_clk);
        #1 chk(8'(secondaryIntN), 8'h01);
      end
    end
    end_of_test();
  end
endmodule : tec_error_link_test
`default_nettype wire
